// File: hw/sar_conv_ctrl.sv
// Purpose: conversion sequencing and parallel/serial result port
// Assumes: all pins asynchronous to clk; sample_code from the sar core
// Notes:   one shared result fifo feeds both pin sets
//
// Functional notes
// - parallel mode: shared pins carry bits 4-11
// - bits 12-15 are outputs in both modes
// - serial bit-9 pin is clock, direction by source
// - clock invert picks the data update edge
// - internal clock: frame sync during valid data
// - slave: unfinished read at completion pulses flag
// - busy high from start until result latched
// - drivers enabled only with select and read low
// - reset pin aborts conversion, returns to acquisition
// - power-down finishes conversion, blocks further starts
// - start high at acquisition end: wait falling edge
// - start low at acquisition end: convert at once
// - source select low: internal clock, else external
// - serial data leaves most significant bit first
// - external clock: update rising, invert swaps edges
// - read mode high shifts during next conversion
`timescale 1ns/1ps

// ------------------------------------------------------------
// result fifo
// ------------------------------------------------------------
module result_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned D = 16
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_q, wp_d, rp_q, rp_d;
  logic         wr, rd;

  always_comb begin
    in_ready  = (wp_q - rp_q) != (AW+1)'(D);
    out_valid = wp_q != rp_q;
    out_data  = mem[rp_q[AW-1:0]];
    wr        = in_valid && in_ready;
    rd        = out_valid && out_ready;
    wp_d      = wr ? wp_q + 1'b1 : wp_q;
    rp_d      = rd ? rp_q + 1'b1 : rp_q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // storage has no reset; empty pointers hide it
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule // result_fifo

// ------------------------------------------------------------
// converter control top
// ------------------------------------------------------------
module sar_conv_ctrl #(
  parameter int unsigned RES_W  = sar_conv_pkg::RES_W,
  parameter int unsigned FIFO_D = sar_conv_pkg::FIFO_D
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             reset_in,
  input  wire logic             power_down_in,
  input  wire logic             convert_start_n,
  input  wire logic             cs_n,
  input  wire logic             rd_n,
  input  wire logic             port_type_select,
  input  wire logic             clock_source_select,
  input  wire logic             shift_clock_invert,
  input  wire logic             frame_marker_polarity,
  input  wire logic             read_mode_or_chain_in,
  input  wire logic             sclk_in,
  input  wire logic [RES_W-1:0] sample_code,
  output logic                  busy,
  output logic      [RES_W-1:0] data_out,
  output logic      [RES_W-1:0] data_oe
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam int unsigned N = sar_conv_pkg::SY_N;
  logic [N-1:0] pin_raw, s1_q, s2_q;
  logic         cnv_p_q, sclk_p_q;
  // strobes rest high so reset shows no false start and no enabled port
  localparam logic [N-1:0] SY_IDLE = N'((1 << sar_conv_pkg::SY_CNV) | (1 << sar_conv_pkg::SY_CS) |
                                        (1 << sar_conv_pkg::SY_RD));

  assign pin_raw = {sclk_in, read_mode_or_chain_in, frame_marker_polarity,
                    shift_clock_invert, clock_source_select, port_type_select,
                    rd_n, cs_n, convert_start_n, power_down_in, reset_in};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q     <= SY_IDLE;
      s2_q     <= SY_IDLE;
      cnv_p_q  <= 1'b1;
      sclk_p_q <= 1'b0;
    end else begin
      s1_q     <= pin_raw;
      s2_q     <= s1_q;
      cnv_p_q  <= s2_q[sar_conv_pkg::SY_CNV];
      sclk_p_q <= s2_q[sar_conv_pkg::SY_SCLK];
    end
  end

  logic rst_pin, pd, cnv_n, ser, ext, inv, pol, rdc, sclk_s, en;
  assign rst_pin = s2_q[sar_conv_pkg::SY_RST];
  assign pd      = s2_q[sar_conv_pkg::SY_PD];
  assign cnv_n   = s2_q[sar_conv_pkg::SY_CNV];
  assign ser     = s2_q[sar_conv_pkg::SY_PTS];
  assign ext     = s2_q[sar_conv_pkg::SY_CSS];
  assign inv     = s2_q[sar_conv_pkg::SY_INV];
  assign pol     = s2_q[sar_conv_pkg::SY_POL];
  assign rdc     = s2_q[sar_conv_pkg::SY_RDC];
  assign sclk_s  = s2_q[sar_conv_pkg::SY_SCLK];
  // select and read are or'd: either high disables the port
  assign en      = !(s2_q[sar_conv_pkg::SY_CS] | s2_q[sar_conv_pkg::SY_RD]);

  // ------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------
  sar_conv_pkg::conv_st_t st_q, st_d;
  logic [sar_conv_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [RES_W-1:0] code_q, code_d;
  logic             push_rdy, conv_go;
  logic             pop_valid, pop_ready;
  logic [RES_W-1:0] pop_data;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    code_d  = code_q;
    conv_go = 1'b0;
    if (rst_pin) begin
      st_d  = sar_conv_pkg::ST_ACQ;
      cnt_d = '0;
    end else begin
      case (st_q)
        sar_conv_pkg::ST_ACQ: begin
          if (cnt_q < sar_conv_pkg::CNT_W'(sar_conv_pkg::ACQ_CYC - 1)) begin
            cnt_d = cnt_q + 1'b1;
          end else if (!pd) begin
            cnt_d = '0;
            if (!cnv_n) begin
              st_d    = sar_conv_pkg::ST_CONV;
              conv_go = 1'b1;
            end else begin
              st_d = sar_conv_pkg::ST_ARM;
            end
          end
        end
        sar_conv_pkg::ST_ARM: begin
          if (cnv_p_q && !cnv_n && !pd) begin
            st_d    = sar_conv_pkg::ST_CONV;
            conv_go = 1'b1;
          end
        end
        sar_conv_pkg::ST_CONV: begin
          // power-down does not cut a running conversion short
          if (cnt_q < sar_conv_pkg::CNT_W'(sar_conv_pkg::CONV_CYC - 1)) begin
            cnt_d = cnt_q + 1'b1;
          end else begin
            cnt_d  = '0;
            code_d = sample_code;
            st_d   = sar_conv_pkg::ST_DONE;
          end
        end
        sar_conv_pkg::ST_DONE: begin
          // a full fifo holds the sequencer here, busy stays high
          if (push_rdy) begin
            st_d = sar_conv_pkg::ST_ACQ;
          end
        end
        default: begin
          st_d  = sar_conv_pkg::ST_ACQ;
          cnt_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= sar_conv_pkg::ST_ACQ;
      cnt_q  <= '0;
      code_q <= '0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      code_q <= code_d;
    end
  end

  result_fifo #(.W(RES_W), .D(FIFO_D)) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (st_q == sar_conv_pkg::ST_DONE && !rst_pin),
    .in_ready  (push_rdy),
    .in_data   (code_q),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  // ------------------------------------------------------------
  // result latch and serial engine
  // ------------------------------------------------------------
  logic [RES_W-1:0] res_q, res_d, sh_q, sh_d;
  logic             fresh_q, fresh_d, frame_q, frame_d, sclk_q, sclk_d;
  logic             flag_q, flag_d;
  logic [2:0]       div_q, div_d;
  logic [sar_conv_pkg::TGL_W-1:0] tgl_q, tgl_d;
  logic [4:0]       cap_q, cap_d;
  logic             pop, upd_e, cap_e, start;

  always_comb begin
    res_d   = res_q;
    sh_d    = sh_q;
    fresh_d = fresh_q;
    frame_d = frame_q;
    sclk_d  = sclk_q;
    div_d   = div_q;
    tgl_d   = tgl_q;
    cap_d   = cap_q;
    flag_d  = 1'b0;
    // no new result over a running internal frame
    pop_ready = !(frame_q && !ext);
    pop       = pop_valid && pop_ready;
    // update edge: rising unless inverted
    upd_e = ext && (inv ? (sclk_p_q && !sclk_s) : (!sclk_p_q && sclk_s));
    cap_e = ext && (inv ? (!sclk_p_q && sclk_s) : (sclk_p_q && !sclk_s));
    start = ser && !ext && !frame_q && en && fresh_q &&
            (rdc ? conv_go : 1'b1);
    if (pop) begin
      res_d   = pop_data;
      sh_d    = pop_data;
      fresh_d = 1'b1;
      if (ext && cap_q != '0 && cap_q != sar_conv_pkg::BITS_ALL) begin
        flag_d = 1'b1;
      end
      cap_d = '0;
    end
    if (!ext) begin
      // internal clock: idle level follows invert
      if (start) begin
        frame_d = 1'b1;
        fresh_d = 1'b0;
        sh_d    = res_d;
        tgl_d   = '0;
        div_d   = '0;
        sclk_d  = inv;
      end else if (frame_q) begin
        if (div_q == 3'(sar_conv_pkg::SCLK_HALF - 1)) begin
          div_d  = '0;
          sclk_d = !sclk_q;
          tgl_d  = tgl_q + 1'b1;
          // odd toggles update; the first one keeps the msb
          if (!tgl_q[0] && tgl_q != '0) begin
            sh_d = {sh_q[RES_W-2:0], 1'b0};
          end
          if (tgl_d == sar_conv_pkg::FRAME_TGL) begin
            frame_d = 1'b0;
          end
        end else begin
          div_d = div_q + 1'b1;
        end
      end else begin
        sclk_d = inv;
      end
    end else begin
      frame_d = 1'b0;
      if (en && !pop) begin
        if (cap_e && cap_q != sar_conv_pkg::BITS_ALL) begin
          cap_d = cap_q + 1'b1;
        end
        // chained device data follows our own bits
        if (upd_e && cap_q != '0) begin
          sh_d = {sh_q[RES_W-2:0], rdc};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      res_q   <= '0;
      sh_q    <= '0;
      fresh_q <= 1'b0;
      frame_q <= 1'b0;
      sclk_q  <= 1'b0;
      div_q   <= '0;
      tgl_q   <= '0;
      cap_q   <= '0;
      flag_q  <= 1'b0;
    end else begin
      res_q   <= res_d;
      sh_q    <= sh_d;
      fresh_q <= fresh_d;
      frame_q <= frame_d;
      sclk_q  <= sclk_d;
      div_q   <= div_d;
      tgl_q   <= tgl_d;
      cap_q   <= cap_d;
      flag_q  <= flag_d;
    end
  end

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  logic             busy_d;
  logic [RES_W-1:0] dout_d, doe_d;

  always_comb begin
    // busy covers the fifo so it falls only when latched
    busy_d = st_q == sar_conv_pkg::ST_CONV || st_q == sar_conv_pkg::ST_DONE ||
             pop_valid;
    dout_d = res_q;
    doe_d  = {RES_W{en}};
    if (ser) begin
      dout_d[sar_conv_pkg::PIN_SDO]  = sh_q[RES_W-1];
      dout_d[sar_conv_pkg::PIN_SCLK] = sclk_q;
      dout_d[sar_conv_pkg::PIN_SYNC] = frame_q ^ pol;
      dout_d[sar_conv_pkg::PIN_FLAG] = flag_q;
      doe_d[sar_conv_pkg::PIN_IN_HI:sar_conv_pkg::PIN_IN_LO] = '0;
      doe_d[sar_conv_pkg::PIN_SCLK]  = en && !ext;
      doe_d[sar_conv_pkg::PIN_SYNC]  = en && !ext;
      doe_d[sar_conv_pkg::PIN_FLAG]  = en && ext;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy     <= 1'b0;
      data_out <= '0;
      data_oe  <= '0;
    end else begin
      busy     <= busy_d;
      data_out <= dout_d;
      data_oe  <= doe_d;
    end
  end
endmodule // sar_conv_ctrl

// File: hw/sar_conv_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: 200 MHz system clock
// Notes:   conversion and acquisition times are plain defaults
package sar_conv_pkg;
  localparam int unsigned RES_W     = 16;
  localparam int unsigned FIFO_D    = 16;
  localparam int unsigned CLK_MHZ   = 200;
  // acquisition and conversion times in ns
  localparam int unsigned ACQ_NS    = 1000;
  localparam int unsigned CONV_NS   = 8000;
  // least times round up to whole cycles
  localparam int unsigned ACQ_CYC   = (ACQ_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_CYC  = (CONV_NS * CLK_MHZ + 999) / 1000;
  // internal shift clock half period in system cycles
  localparam int unsigned SCLK_HALF = 4;
  localparam int unsigned CNT_W     = 16;
  localparam int unsigned TGL_W     = 6;
  // toggles in one internal frame: 16 bits, two edges each
  localparam logic [5:0]  FRAME_TGL = 6'h20;
  localparam logic [4:0]  BITS_ALL  = 5'h10;
  // shared pin positions
  localparam int unsigned PIN_SDO   = 8;
  localparam int unsigned PIN_SCLK  = 9;
  localparam int unsigned PIN_SYNC  = 10;
  localparam int unsigned PIN_FLAG  = 11;
  localparam int unsigned PIN_IN_LO = 4;
  localparam int unsigned PIN_IN_HI = 7;
  // synchroniser lane positions
  localparam int unsigned SY_RST  = 0;
  localparam int unsigned SY_PD   = 1;
  localparam int unsigned SY_CNV  = 2;
  localparam int unsigned SY_CS   = 3;
  localparam int unsigned SY_RD   = 4;
  localparam int unsigned SY_PTS  = 5;
  localparam int unsigned SY_CSS  = 6;
  localparam int unsigned SY_INV  = 7;
  localparam int unsigned SY_POL  = 8;
  localparam int unsigned SY_RDC  = 9;
  localparam int unsigned SY_SCLK = 10;
  localparam int unsigned SY_N    = 11;
  typedef enum logic [1:0] {ST_ACQ, ST_ARM, ST_CONV, ST_DONE} conv_st_t;
endpackage

// File: sim/host_model.sv
// Purpose: host reading serial results as clock master or slave
// Assumes: own shift clock half period 24 ns
// Notes:   done stays high until go drops
`timescale 1ns/1ps
module host_model (
  input  wire logic        ext,
  input  wire logic        inv,
  input  wire logic        pol,
  input  wire logic        go,
  input  wire logic [4:0]  nbits,
  input  wire logic        sdo,
  input  wire logic        sclk_dev,
  input  wire logic        sync,
  output logic             sclk,
  output logic             done,
  output logic      [15:0] word
);
  logic       ph;
  logic [4:0] n;
  // clock rests at its idle level outside frames, first edge captures
  assign sclk = ph ^ !inv;
  initial begin
    {ph, done, n} = '0;
    word = 16'h0;
    forever begin
      wait (go && ext);
      #7;
      for (int i = 0; i < nbits; i++) begin
        #24 ph = 1'b1;
        word = {word[14:0], sdo};
        #24 ph = 1'b0;
      end
      if (nbits == 5'h10) done = 1'b1;
      wait (!go);
    end
  end
  // count captures, not marker edges: the marker drops on the last capture edge
  always @(sclk_dev) begin
    if (go && !ext && n != 5'h10 && sclk_dev == inv) begin
      word = {word[14:0], sdo};
      n = n + 5'h1;
      if (n == 5'h10) done = 1'b1;
    end
  end
  always @(posedge (sync ^ pol)) n = 5'h0;
  always @(negedge go) done = 1'b0;
endmodule // host_model

// File: sim/sar_conv_chk.sv
// Purpose: port checks for sar_conv_ctrl
// Assumes: pins settle in 2-3 clk
// Notes:   modes held still while reading
`timescale 1ns/1ps
module sar_conv_chk #(
  parameter int unsigned RES_W  = 16,
  parameter int unsigned FIFO_D = 16
) (
  input wire logic             clk,
  input wire logic             arst_n,
  input wire logic             reset_in,
  input wire logic             power_down_in,
  input wire logic             convert_start_n,
  input wire logic             cs_n,
  input wire logic             rd_n,
  input wire logic             port_type_select,
  input wire logic             clock_source_select,
  input wire logic             shift_clock_invert,
  input wire logic             frame_marker_polarity,
  input wire logic             read_mode_or_chain_in,
  input wire logic             sclk_in,
  input wire logic [RES_W-1:0] sample_code,
  input wire logic             busy,
  input wire logic [RES_W-1:0] data_out,
  input wire logic [RES_W-1:0] data_oe
);
  // -------
  // helpers
  // -------
  logic        act;
  logic [7:0]  run_d, run_q;
  logic [15:0] hi_d, hi_q;
  // run length of an active frame marker; wraps only if it sticks
  assign act = port_type_select && !clock_source_select && data_oe[10]
               && (data_out[10] ^ frame_marker_polarity);
  always_comb begin
    run_d = act ? run_q + 8'h1 : 8'h0;
    hi_d  = busy ? hi_q + 16'h1 : 16'h0;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 8'h0;
      hi_q  <= 16'h0;
    end else begin
      run_q <= run_d;
      hi_q  <= hi_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_par; (!port_type_select && !cs_n && !rd_n)[*5]; endsequence
  sequence s_ser; (port_type_select && !cs_n && !rd_n && $stable(clock_source_select))[*5]; endsequence
  property p_off; (cs_n || rd_n)[*5] |-> data_oe == '0; endproperty
  property p_par; s_par |-> data_oe == '1; endproperty
  property p_ser; s_ser |-> data_oe[15:12] == 4'hf && data_oe[9] == !clock_source_select; endproperty
  property p_len; $fell(busy) && !reset_in |-> hi_q >= sar_conv_pkg::CONV_CYC; endproperty
  property p_abort; reset_in[*5] |-> !busy; endproperty
  property p_pd; (power_down_in[*8] ##0 !busy) |=> !busy; endproperty
  property p_start; $rose(busy) |-> !$past(convert_start_n, 3); endproperty
  property p_flag; port_type_select && clock_source_select && data_oe[11] && data_out[11] |=> !data_out[11];
  endproperty
  property p_sync; !act && run_q != 8'h0 |-> run_q == 8'h80; endproperty
  a_off: assert property (p_off)
    else $error("drivers on while deselected");
  a_par: assert property (p_par)
    else $error("parallel drivers off");
  a_ser: assert property (p_ser)
    else $error("serial pin directions wrong");
  a_len: assert property (p_len)
    else $error("busy too short");
  a_abort: assert property (p_abort)
    else $error("busy during reset");
  a_pd: assert property (p_pd)
    else $error("start in power down");
  a_start: assert property (p_start)
    else $error("busy without start");
  a_flag: assert property (p_flag)
    else $error("flag longer than a pulse");
  a_sync: assert property (p_sync)
    else $error("frame marker length wrong");
endmodule // sar_conv_chk
bind sar_conv_ctrl sar_conv_chk #(.RES_W(RES_W), .FIFO_D(FIFO_D)) u_chk (
  .clk, .arst_n, .reset_in, .power_down_in, .convert_start_n, .cs_n, .rd_n, .port_type_select,
  .clock_source_select, .shift_clock_invert, .frame_marker_polarity, .read_mode_or_chain_in,
  .sclk_in, .sample_code, .busy, .data_out, .data_oe);

// File: sim/testbench.sv
// Purpose: self-checking bench for sar_conv_ctrl
// Assumes: sar core replaced by random codes
// Notes:   host model reads serial words
`timescale 1ns/1ps
module testbench;
  logic        clk, arst_n, reset_in, power_down_in, convert_start_n, cs_n, rd_n, go;
  logic        port_type_select, clock_source_select, shift_clock_invert;
  logic        frame_marker_polarity, read_mode_or_chain_in, sclk_in, busy, h_done;
  logic [4:0]  nbits;
  logic [15:0] sample_code, data_out, data_oe, h_word, last;
  logic [15:0] q[$];
  int          fails, n_checks, flags;
  sar_conv_ctrl u_dut (.clk, .arst_n, .reset_in, .power_down_in, .convert_start_n, .cs_n, .rd_n,
    .port_type_select, .clock_source_select, .shift_clock_invert, .frame_marker_polarity,
    .read_mode_or_chain_in, .sclk_in, .sample_code, .busy, .data_out, .data_oe);
  host_model u_host (.ext(clock_source_select), .inv(shift_clock_invert), .pol(frame_marker_polarity),
    .go, .nbits, .sdo(data_oe[8] ? data_out[8] : !data_out[8]),
    .sclk_dev(data_out[9]), .sync(data_out[10]), .sclk(sclk_in),
    .done(h_done), .word(h_word));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    // an expected word never read back is a miss too
    fails += q.size();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one conversion; mid[0] powers down, mid[1] aborts by reset
  task automatic convert(input bit now, input logic [1:0] mid, input bit keep);
    logic [15:0] v;
    @(posedge clk);
    v = 16'($urandom);
    if (keep) q.push_back(v);
    if (!now) repeat (260) @(posedge clk);
    sample_code     <= v;
    convert_start_n <= 1'b0;
    for (int i = 0; i < 400 && busy !== 1'b1; i++) @(posedge clk);
    check(16'(busy), 16'h1);
    repeat (8) @(posedge clk);
    convert_start_n <= 1'b1;
    power_down_in   <= mid[0];
    reset_in        <= mid[1];
    for (int i = 0; i < 2500 && busy !== 1'b0; i++) @(posedge clk);
    check(16'(busy), 16'h0);
    repeat (4) @(posedge clk);
    reset_in <= 1'b0;
    if (!mid[1]) last = v;
  endtask
  task automatic fetch();
    for (int i = 0; i < 400 && h_done !== 1'b1; i++) @(posedge clk);
    go <= 1'b0;
  endtask
  // busy fall is the host's cue that a fresh word waits
  always @(negedge busy) begin
    #1;
    if (!port_type_select && q.size() > 0) check(data_out, q.pop_front());
  end
  always @(posedge h_done) if (q.size() > 0) check(h_word, q.pop_front());
  always @(posedge clk) if (port_type_select && clock_source_select && data_oe[11] && data_out[11]) flags++;
  initial begin
    {arst_n, reset_in, power_down_in, rd_n, go, port_type_select, clock_source_select} = '0;
    {shift_clock_invert, frame_marker_polarity, read_mode_or_chain_in} = '0;
    {convert_start_n, cs_n} = 2'h3;
    nbits       = 5'h10;
    sample_code = 16'h0;
    void'($urandom(78));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    cs_n   <= 1'b0;
    convert(0, 2'h0, 1);
    convert(1, 2'h0, 1);
    convert(1, 2'h1, 1);
    convert_start_n <= 1'b0;
    repeat (600) @(posedge clk);
    check(16'(busy), 16'h0);
    power_down_in <= 1'b0;
    convert(1, 2'h0, 1);
    convert(0, 2'h2, 0);
    check(data_out, last);
    cs_n <= 1'b1;
    repeat (6) @(posedge clk);
    check(data_oe, 16'h0);
    port_type_select    <= 1'b1;
    clock_source_select <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      cs_n               <= 1'b1;
      shift_clock_invert <= k[0];
      repeat (4) @(posedge clk);
      cs_n <= 1'b0;
      convert(0, 2'h0, 1);
      go <= 1'b1;
      fetch();
    end
    convert(0, 2'h0, 0);
    nbits <= 5'h5;
    go    <= 1'b1;
    fetch();
    nbits <= 5'h10;
    convert(1, 2'h0, 1);
    go <= 1'b1;
    fetch();
    check(16'(flags), 16'h1);
    cs_n                <= 1'b1;
    clock_source_select <= 1'b0;
    shift_clock_invert  <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      frame_marker_polarity <= k[0];
      read_mode_or_chain_in <= k[1];
      repeat (4) @(posedge clk);
      cs_n <= 1'b0;
      repeat (200) @(posedge clk);
      go <= 1'b1;
      convert(0, 2'h0, 1);
      if (k[1]) convert(1, 2'h0, 0);
      fetch();
      cs_n <= 1'b1;
      // let the port close before the marker polarity moves
      repeat (4) @(posedge clk);
    end
    conclude();
  end
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule // testbench
